// >>> dv/pie_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pie_ctrl_asserts (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic irq_high_o,
   input wire logic irq_low_o
);
   logic [1:0] ctl_q;
   // priority mode and global enable bits mirrored here, as the port does not show them
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i)
         ctl_q <= 2'h0;
      else if (reg_wr_i && reg_addr_i == 4'h5)
         ctl_q <= reg_wdata_i[1:0];
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   a_unmap_zero: assert property (
      reg_rd_i && reg_addr_i[3] |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_en2_unused: assert property (
      reg_rd_i && reg_addr_i == 4'h0 |=> (reg_rdata_o & 8'h6A) == 8'h00)
      else $error("enable 2 spare bits not zero");
   a_en3_unused: assert property (
      reg_rd_i && reg_addr_i == 4'h1 |=> reg_rdata_o[7:5] == 3'h0)
      else $error("enable 3 spare bits not zero");
   a_pr1_unused: assert property (
      reg_rd_i && reg_addr_i == 4'h2 |=> !reg_rdata_o[7])
      else $error("priority 1 bit 7 not zero");
   a_en2_wr_rd: assert property (
      reg_wr_i && reg_addr_i == 4'h0 ##1 reg_rd_i && reg_addr_i == 4'h0
      |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h95))
      else $error("enable 2 readback wrong");
   a_pr1_wr_rd: assert property (
      reg_wr_i && reg_addr_i == 4'h2 ##1 reg_rd_i && reg_addr_i == 4'h2
      |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h7F))
      else $error("priority 1 readback wrong");
   a_high_mode: assert property (
      !$past(ctl_q[0]) |-> !irq_high_o)
      else $error("high request without priority mode");
   a_low_global: assert property (
      !$past(ctl_q[0]) && !$past(ctl_q[1]) |-> !irq_low_o)
      else $error("request without global enable");
   c_high: cover property (irq_high_o);
   c_low: cover property (irq_low_o);
   c_unmap: cover property (reg_rd_i && reg_addr_i[3]);
endmodule // pie_ctrl_asserts
bind pie_ctrl pie_ctrl_asserts i_chk (.core_clk_i(core_clk_i),
   .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .irq_high_o(irq_high_o), .irq_low_o(irq_low_o));
`default_nettype wire

// >>> dv/pie_src.sv
`timescale 1ns/1ps
`default_nettype none
module pie_src (
   input wire logic core_clk_i,
   input wire logic [27:0] ev_i,
   output logic [27:0] line_o
);
   // sources move their level flags only on the clock edge
   always_ff @(posedge core_clk_i) begin
      line_o <= ev_i;
   end
endmodule // pie_src
`default_nettype wire

// >>> dv/test_peripheral_irq_enable_priority.sv
`timescale 1ns/1ps
`default_nettype none
module test_peripheral_irq_enable_priority;
   logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, hi, lo, irq, iq;
   logic [3:0] a = 4'h0;
   logic [7:0] wd = 8'h00, en1 = 8'h00, rdat, v;
   logic [27:0] ev = 28'h0, ln;
   int n_fail = 0, n_checks = 0, cyc = 0, i;
   logic [7:0] rv [9] = '{0, 0, 8'h7F, 8'h95, 8'h1F, 0, 0, 0, 0};
   logic [7:0] mk [9] = '{8'h95, 8'h1F, 8'h7F, 8'h95, 8'h1F, 8'h07, 0,
      8'h07, 0};
   int evb [11] = '{15, 12, 10, 8, 20, 17, 16, 24, 25, 26, 27};
   logic [7:0] eb [11] = '{8'h80, 8'h10, 8'h04, 8'h01, 8'h10, 8'h02, 8'h01,
      8'h08, 8'h04, 8'h08, 8'h04};
   initial forever #10 clk = ~clk;
   pie_src i_src (.core_clk_i(clk), .ev_i(ev), .line_o(ln));
   pie_ctrl i_dut (.core_clk_i(clk), .rstn_i(rstn), .reg_addr_i(a),
      .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
      .flag1_i(ln[7:0]), .flag2_i(ln[15:8]), .flag3_i(ln[23:16]),
      .enable1_i(en1), .cap3_i(ln[24]), .cap2_i(ln[25]),
      .dir_change_i(ln[26]), .position_i(ln[27]), .irq_high_o(hi),
      .irq_low_o(lo), .irq_o(irq));
   task end_sim;
      if (n_fail == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string s, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask
   task w(input logic [3:0] ad, input logic [7:0] d);
      wr <= 1'b1;
      rd <= 1'b0;
      a <= ad;
      wd <= d;
      @(posedge clk);
   endtask
   // read data stand one cycle only, so they are taken just after that edge
   task r(input logic [3:0] ad);
      rd <= 1'b1;
      wr <= 1'b0;
      a <= ad;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdat;
      iq = irq;
      @(posedge clk);
   endtask
   // one edge through the sources, one through the request output register
   task ev_set(input logic [27:0] e, input logic h, input logic l);
      ev <= e;
      wr <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk("irq_high", {7'h0, h}, {7'h0, hi});
      chk("irq_low", {7'h0, l}, {7'h0, lo});
      @(posedge clk);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc > 3000) begin
         n_fail++;
         end_sim;
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      for (i = 0; i < 9; i++) begin
         r(i[3:0]);
         chk("reset value", rv[i], v);
      end
      for (i = 0; i < 9; i++) begin
         if (i != 6) begin
            w(i[3:0], 8'hFF);
            r(i[3:0]);
            chk("readback", mk[i], v);
         end
      end
      en1 <= 8'h7F;
      w(5, 8'h01);
      for (i = 0; i < 7; i++) begin
         w(2, 8'h01 << i);
         ev_set(28'h1 << i, 1'b1, 1'b0);
         w(2, 8'h00);
         ev_set(28'h1 << i, 1'b0, 1'b1);
      end
      w(2, 8'h7F);
      w(5, 8'h00);
      ev_set(28'h40, 1'b0, 1'b0);
      w(5, 8'h02);
      ev_set(28'h40, 1'b0, 1'b1);
      en1 <= 8'h00;
      ev_set(28'h40, 1'b0, 1'b0);
      for (i = 0; i < 11; i++) begin
         w(5, {5'h0, i > 8, 2'b10});
         w({3'h0, i > 3}, 8'h00);
         ev_set(28'h1 << evb[i], 1'b0, 1'b0);
         w({3'h0, i > 3}, eb[i]);
         ev_set(28'h1 << evb[i], 1'b0, 1'b1);
         if (i > 6) begin
            w(5, {5'h0, i < 9, 2'b10});
            ev_set(28'h1 << evb[i], 1'b0, 1'b0);
         end
      end
      ev_set(28'h0, 1'b0, 1'b0);
      w(6, 8'h07);
      r(6);
      chk("status", 8'h00, v);
      w(5, 8'h06);
      w(7, 8'h02);
      ev_set(28'h8000000, 1'b0, 1'b1);
      r(6);
      chk("status", 8'h06, v);
      chk("irq", 8'h01, {7'h0, iq});
      w(7, 8'h00);
      r(6);
      chk("irq masked", 8'h00, {7'h0, iq});
      w(7, 8'h02);
      w(6, 8'h02);
      r(6);
      chk("status", 8'h04, v);
      chk("irq cleared", 8'h00, {7'h0, iq});
      end_sim;
   end
endmodule // test_peripheral_irq_enable_priority
`default_nettype wire

// >>> logic/pie_ctrl.v
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - priority bits count only in priority mode
// - three priority registers beside enable registers
// - priority 1 bit 6: converter priority
// - priority 1 bit 5: serial receive priority
// - priority 1 bit 4: serial transmit priority
// - priority 1 bit 3: sync serial priority
// - priority 1 bit 2: capture/compare 1 priority
// - priority 1 bit 1: timer 2 match priority
// - priority 1 bit 0: timer 1 overflow priority
// - enable 2 bit 2 gates low voltage
// - enable 2 bit 4 gates data memory write
// - unimplemented bits ignore writes, read zero
// - without priority mode, global enable also needed
`include "pie_defs.vh"
module pie_ctrl (
   input wire core_clk_i,
   input wire rstn_i,
   input wire [3:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [7:0] reg_rdata_o,
   // flags of group 1 (priority 1 layout), 2 and 3 (enable layouts)
   input wire [7:0] flag1_i,
   input wire [7:0] flag2_i,
   input wire [7:0] flag3_i,
   // enable bits of group 1 live in another block
   input wire [7:0] enable1_i,
   // raw capture and quadrature event lines
   input wire cap3_i,
   input wire cap2_i,
   input wire dir_change_i,
   input wire position_i,
   output reg irq_high_o,
   output reg irq_low_o,
   output reg irq_o
);
   reg [7:0] enable2_q;
   reg [7:0] enable3_q;
   reg [7:0] prio1_q;
   reg [7:0] prio2_q;
   reg [7:0] prio3_q;
   reg [7:0] control_q;
   reg [7:0] status_q;
   reg [7:0] mask_q;
   reg [7:0] status_d;
   reg [7:0] rdata_d;
   reg [7:0] flag3_sel;
   wire prio_mode;
   wire global_en;
   wire quad_mode;
   wire [23:0] active;
   wire [23:0] high;
   wire [23:0] low;
   wire high_any;
   wire low_any;
   reg high_d;
   reg low_d;
   reg high_prev_q;
   reg low_prev_q;

   function is_wr;
      input [3:0] addr;
      input [3:0] ofs;
      begin
         is_wr = reg_wr_i && (addr == ofs);
      end
   endfunction

   assign prio_mode = control_q[`PIE_CTL_PRIO_MODE];
   assign global_en = control_q[`PIE_CTL_GLOBAL_PERIPH];
   assign quad_mode = control_q[`PIE_CTL_QUAD_MODE];

   // bits 3,2 of group 3 follow the selected capture or decoder source
   always @* begin
      flag3_sel = flag3_i;
      flag3_sel[`PIE_BIT_CAP3_DIR] = quad_mode ? dir_change_i : cap3_i;
      flag3_sel[`PIE_BIT_CAP2_POS] = quad_mode ? position_i : cap2_i;
   end

   // group 1 uses the priority 1 layout: converter, serial, timers
   pie_gate u_gate1 (
      .flag_i(flag1_i),
      .enable_i(enable1_i),
      .priority_i(prio1_q),
      .prio_mode_i(prio_mode),
      .active_o(active[7:0]),
      .high_o(high[7:0]),
      .low_o(low[7:0])
   );
   pie_gate u_gate2 (
      .flag_i(flag2_i),
      .enable_i(enable2_q),
      .priority_i(prio2_q),
      .prio_mode_i(prio_mode),
      .active_o(active[15:8]),
      .high_o(high[15:8]),
      .low_o(low[15:8])
   );
   pie_gate u_gate3 (
      .flag_i(flag3_sel),
      .enable_i(enable3_q),
      .priority_i(prio3_q),
      .prio_mode_i(prio_mode),
      .active_o(active[23:16]),
      .high_o(high[23:16]),
      .low_o(low[23:16])
   );

   assign high_any = |high;
   assign low_any = |low;

   // legacy mode needs the global peripheral enable too
   always @* begin
      if (prio_mode) begin
         high_d = high_any;
         low_d = low_any;
      end else begin
         high_d = 1'b0;
         low_d = low_any & global_en;
      end
   end

   // sticky events: rising of the high and low request lines, pending while either is set; set wins over clear
   always @* begin
      status_d = status_q;
      if (is_wr(reg_addr_i, `PIE_OFS_STATUS))
         status_d = status_q & ~(reg_wdata_i & `PIE_EV_MASK);
      if (high_d && !high_prev_q)
         status_d[`PIE_EV_HIGH] = 1'b1;
      if (low_d && !low_prev_q)
         status_d[`PIE_EV_LOW] = 1'b1;
      if (high_d || low_d)
         status_d[`PIE_EV_PEND] = 1'b1;
   end

   always @* begin
      case (reg_addr_i)
         `PIE_OFS_ENABLE_2: rdata_d = enable2_q;
         `PIE_OFS_ENABLE_3: rdata_d = enable3_q;
         `PIE_OFS_PRIORITY_1: rdata_d = prio1_q;
         `PIE_OFS_PRIORITY_2: rdata_d = prio2_q;
         `PIE_OFS_PRIORITY_3: rdata_d = prio3_q;
         `PIE_OFS_CONTROL: rdata_d = control_q;
         `PIE_OFS_STATUS: rdata_d = status_q;
         `PIE_OFS_MASK: rdata_d = mask_q;
         default: rdata_d = 8'h00;
      endcase
   end

   always @(posedge core_clk_i) begin
      if (!rstn_i) begin
         enable2_q <= `PIE_ENABLE_RST;
         enable3_q <= `PIE_ENABLE_RST;
         prio1_q <= `PIE_PRIORITY_1_RST;
         prio2_q <= `PIE_PRIORITY_2_RST;
         prio3_q <= `PIE_PRIORITY_3_RST;
         control_q <= `PIE_CONTROL_RST;
         status_q <= 8'h00;
         mask_q <= 8'h00;
         reg_rdata_o <= 8'h00;
         irq_high_o <= 1'b0;
         irq_low_o <= 1'b0;
         irq_o <= 1'b0;
         high_prev_q <= 1'b0;
         low_prev_q <= 1'b0;
      end else begin
         // masking on write keeps unimplemented bits at zero
         if (is_wr(reg_addr_i, `PIE_OFS_ENABLE_2))
            enable2_q <= reg_wdata_i & `PIE_ENABLE_2_MASK;
         if (is_wr(reg_addr_i, `PIE_OFS_ENABLE_3))
            enable3_q <= reg_wdata_i & `PIE_ENABLE_3_MASK;
         if (is_wr(reg_addr_i, `PIE_OFS_PRIORITY_1))
            prio1_q <= reg_wdata_i & `PIE_PRIORITY_1_MASK;
         if (is_wr(reg_addr_i, `PIE_OFS_PRIORITY_2))
            prio2_q <= reg_wdata_i & `PIE_PRIORITY_2_MASK;
         if (is_wr(reg_addr_i, `PIE_OFS_PRIORITY_3))
            prio3_q <= reg_wdata_i & `PIE_PRIORITY_3_MASK;
         if (is_wr(reg_addr_i, `PIE_OFS_CONTROL))
            control_q <= reg_wdata_i & `PIE_CONTROL_MASK;
         if (is_wr(reg_addr_i, `PIE_OFS_MASK))
            mask_q <= reg_wdata_i & `PIE_EV_MASK;
         status_q <= status_d;
         // no stale data: output reads zero unless a read is strobed
         if (reg_rd_i)
            reg_rdata_o <= rdata_d;
         else
            reg_rdata_o <= 8'h00;
         // registered requests add one cycle of latency to the cpu
         irq_high_o <= high_d;
         irq_low_o <= low_d;
         high_prev_q <= high_d;
         low_prev_q <= low_d;
         irq_o <= |(status_d & mask_q);
      end
   end
endmodule // pie_ctrl
`default_nettype wire

// >>> logic/pie_defs.vh
`ifndef PIE_DEFS_VH
`define PIE_DEFS_VH
// register offsets on the plain register port
`define PIE_ADDR_W 4
`define PIE_OFS_ENABLE_2 4'h0
`define PIE_OFS_ENABLE_3 4'h1
`define PIE_OFS_PRIORITY_1 4'h2
`define PIE_OFS_PRIORITY_2 4'h3
`define PIE_OFS_PRIORITY_3 4'h4
`define PIE_OFS_CONTROL 4'h5
`define PIE_OFS_STATUS 4'h6
`define PIE_OFS_MASK 4'h7
// writable bits of each register
`define PIE_ENABLE_2_MASK 8'h95
`define PIE_ENABLE_3_MASK 8'h1F
`define PIE_PRIORITY_1_MASK 8'h7F
`define PIE_PRIORITY_2_MASK 8'h95
`define PIE_PRIORITY_3_MASK 8'h1F
`define PIE_CONTROL_MASK 8'h07
// reset values
`define PIE_ENABLE_RST 8'h00
`define PIE_PRIORITY_1_RST 8'h7F
`define PIE_PRIORITY_2_RST 8'h95
`define PIE_PRIORITY_3_RST 8'h1F
`define PIE_CONTROL_RST 8'h00
// field positions
`define PIE_BIT_OSC_FAIL 7
`define PIE_BIT_DATA_MEM 4
`define PIE_BIT_LOW_VOLT 2
`define PIE_BIT_CAPCOMP2 0
`define PIE_BIT_PWM_TB 4
`define PIE_BIT_CAP3_DIR 3
`define PIE_BIT_CAP2_POS 2
`define PIE_BIT_CAP1 1
`define PIE_BIT_TIMER5 0
`define PIE_BIT_CONVERTER 6
`define PIE_BIT_SER_RX 5
`define PIE_BIT_SER_TX 4
`define PIE_BIT_SYNC_SER 3
`define PIE_BIT_CAPCOMP1 2
`define PIE_BIT_TIMER2 1
`define PIE_BIT_TIMER1 0
`define PIE_CTL_PRIO_MODE 0
`define PIE_CTL_GLOBAL_PERIPH 1
`define PIE_CTL_QUAD_MODE 2
// event status bits
`define PIE_EV_HIGH 0
`define PIE_EV_LOW 1
`define PIE_EV_PEND 2
`define PIE_EV_MASK 8'h07
`endif

// >>> logic/pie_gate.v
`timescale 1ns/1ps
`default_nettype none
// per-source gating: enable AND flag, split by priority
module pie_gate (
   input wire [7:0] flag_i,
   input wire [7:0] enable_i,
   input wire [7:0] priority_i,
   input wire prio_mode_i,
   output wire [7:0] active_o,
   output wire [7:0] high_o,
   output wire [7:0] low_o
);
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_src
         assign active_o[g] = flag_i[g] & enable_i[g];
         // priority only counts while priority mode is on
         assign high_o[g] = active_o[g] & prio_mode_i & priority_i[g];
         assign low_o[g] = active_o[g] & ~(prio_mode_i & priority_i[g]);
      end
   endgenerate
endmodule // pie_gate
`default_nettype wire
